/* gar_pkg.sv */
// Shared constants for the pin mux, antenna and strength block
package gar_pkg;
  // Register offsets
  localparam logic [6:0] REG_CTRL2 = 7'h08;
  localparam logic [6:0] REG_PIN0_CFG = 7'h0B;
  localparam logic [6:0] REG_PIN1_CFG = 7'h0C;
  localparam logic [6:0] REG_PIN2_CFG = 7'h0D;
  localparam logic [6:0] REG_IO_PORT = 7'h0E;
  localparam logic [6:0] REG_STRENGTH = 7'h26;
  localparam logic [6:0] REG_THRESHOLD = 7'h27;
  localparam logic [6:0] REG_DEV_STATUS = 7'h02;
  localparam logic [6:0] REG_IRQ_STATUS = 7'h04;
  // Reset values
  localparam logic [7:0] CTRL2_RST = 8'h00;
  localparam logic [7:0] PIN_CFG_RST = 8'h00;
  localparam logic [7:0] IO_PORT_RST = 8'h00;
  localparam logic [7:0] THRESHOLD_RST = 8'h00;
  localparam logic [7:0] STRENGTH_RST = 8'h00;
  // Field positions
  localparam int ANT_MODE_LSB = 5;
  localparam int PIN_FUNC_LSB = 0;
  localparam int PIN_PULLUP_BIT = 5;
  localparam int PIN_DRIVE_LSB = 6;
  localparam int STAT_EXT_IRQ_BIT = 0;
  localparam int STAT_CLEAR_CH_BIT = 4;
  // Pin function codes
  localparam logic [4:0] FN_DEFAULT = 5'h00;
  localparam logic [4:0] FN_EXT_IRQ_RISE = 5'h05;
  localparam logic [4:0] FN_TX_CLK = 5'h0A;
  localparam logic [4:0] FN_TX_DATA = 5'h0B;
  localparam logic [4:0] FN_CLEAR_CH = 5'h0E;
  localparam logic [4:0] FN_TX_RX_SWITCH = 5'h12;
  localparam logic [4:0] FN_ANT1 = 5'h17;
  localparam logic [4:0] FN_ANT2 = 5'h18;
  // Timing
  localparam int CLK_PERIOD_NS = 10;
  localparam int STRENGTH_UPDATE_NS = 10;
  localparam int STRENGTH_UPDATE_CYC =
    (STRENGTH_UPDATE_NS / CLK_PERIOD_NS) < 1 ? 1 : (STRENGTH_UPDATE_NS / CLK_PERIOD_NS);
  localparam logic [1:0] REFRESH_LAST_BIT = 2'h3;
  localparam int NUM_PINS = 3;
  typedef logic [1:0] gar_pin_idx_t;
endpackage

/* gar_link_if.sv */
// Pad-level link between the transceiver pins and the host board
`timescale 1ns/100ps
`default_nettype none
interface gar_link_if;
  logic [2:0] dev_o;
  logic [2:0] dev_oe;
  logic [2:0] dev_pu;
  logic [2:0] host_o;
  logic [2:0] host_oe;
  wire logic [2:0] pad;
  // Device drive wins, then host, then the pull-up, else low
  assign pad = (dev_oe & dev_o) | (~dev_oe & host_oe & host_o) | (~dev_oe & ~host_oe & dev_pu);
  modport dev (output dev_o, output dev_oe, output dev_pu, input host_o, input host_oe, input pad);
  modport host (output host_o, output host_oe, input dev_o, input dev_oe, input dev_pu, input pad);
endinterface
`default_nettype wire

/* gar_ant_div.sv */
// Antenna selection: fixed table modes and the diversity search
`timescale 1ns/100ps
`default_nettype none
module gar_ant_div (
  // Clock and reset
  input wire logic i_core_clk,
  input wire logic i_rst_n,
  // Mode and radio state
  input wire logic [2:0] i_mode,
  input wire logic i_active,
  input wire logic i_rx_entry,
  input wire logic i_preamble,
  input wire logic i_sample,
  input wire logic [7:0] i_strength,
  // Results
  output logic o_ant1,
  output logic o_ant2,
  output logic [7:0] o_best,
  output logic o_eval_done
);
  import gar_pkg::*;
  logic sel_q;
  logic probe_q;
  logic seen1_q;
  logic seen2_q;
  logic pre_q;
  logic done_q;
  logic [7:0] s1_q;
  logic [7:0] s2_q;
  logic [7:0] best_q;
  logic beacon;
  assign beacon = i_mode[1];

  // Alternate antennas while the preamble lasts; beacon keeps first sample only
  always_ff @(posedge i_core_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      probe_q <= 1'b0;
      seen1_q <= 1'b0;
      seen2_q <= 1'b0;
      s1_q <= 8'h00;
      s2_q <= 8'h00;
    end else if (i_rx_entry) begin
      probe_q <= 1'b0;
      seen1_q <= 1'b0;
      seen2_q <= 1'b0;
      s1_q <= 8'h00;
      s2_q <= 8'h00;
    end else if (i_preamble && i_sample && i_mode[2]) begin
      probe_q <= ~probe_q;
      if (!probe_q && !(beacon && seen1_q)) begin
        seen1_q <= 1'b1;
        if (i_strength > s1_q) s1_q <= i_strength;
      end
      if (probe_q && !(beacon && seen2_q)) begin
        seen2_q <= 1'b1;
        if (i_strength > s2_q) s2_q <= i_strength;
      end
    end
  end

  // Decide at the end of the preamble and hold for rx and next tx
  always_ff @(posedge i_core_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      pre_q <= 1'b0;
      sel_q <= 1'b0;
      best_q <= 8'h00;
      done_q <= 1'b0;
    end else begin
      pre_q <= i_preamble;
      done_q <= pre_q && !i_preamble;
      if (pre_q && !i_preamble) begin
        sel_q <= i_mode[2] ? (s2_q > s1_q) : 1'b0;
        best_q <= (s2_q > s1_q) ? s2_q : s1_q;
      end
    end
  end

  always_comb begin
    if (!i_active) begin
      o_ant1 = i_mode[2] ? i_mode[0] : i_mode[1];
      o_ant2 = o_ant1;
    end else if (!i_mode[2]) begin
      o_ant1 = i_mode[0];
      o_ant2 = ~i_mode[0];
    end else begin
      o_ant1 = i_preamble ? ~probe_q : ~sel_q;
      o_ant2 = ~o_ant1;
    end
  end
  assign o_best = best_q;
  assign o_eval_done = done_q;
endmodule
`default_nettype wire

/* gar_dev.sv */
// Transceiver end: pin mux, antenna control, strength readout
`timescale 1ns/100ps
`default_nettype none
module gar_dev (
  // Clock and reset
  input wire logic i_core_clk,
  input wire logic i_rst_n,
  // Pads
  gar_link_if.dev link,
  // Radio state
  input wire logic i_shutdown,
  input wire logic i_rx_state,
  input wire logic i_tx_state,
  input wire logic i_por,
  input wire logic i_mcu_clk,
  input wire logic i_direct_tx,
  input wire logic i_bit_tick,
  input wire logic i_preamble,
  input wire logic [7:0] i_strength_raw,
  // Register port
  input wire logic [6:0] i_reg_addr,
  input wire logic [7:0] i_reg_wdata,
  input wire logic i_reg_we,
  input wire logic i_reg_re,
  output logic [7:0] o_reg_rdata,
  // Status and direct data
  output logic o_ext_irq,
  output logic o_clear_channel,
  output logic o_tx_data,
  output logic o_tx_data_valid,
  output logic [5:0] o_pin_drive_strength
);
  import gar_pkg::*;
  logic [7:0] ctrl2_q;
  logic [7:0] cfg_q [NUM_PINS];
  logic [7:0] io_port_q;
  logic [7:0] thr_q;
  logic [7:0] strength_q;
  logic [7:0] rdata_q;
  logic [1:0] bit_cnt_q;
  logic [2:0] pad_in_q;
  logic [2:0] pad_o_q;
  logic [2:0] pad_oe_q;
  logic [2:0] pad_pu_q;
  logic ext_q;
  logic cc_q;
  logic tx_rx_switch_q;
  logic tx_clk_q;
  logic tx_data_q;
  logic tx_valid_q;
  logic active_q;
  logic rx_q;
  logic rx_entry;
  logic ant1;
  logic ant2;
  logic eval_done;
  logic [7:0] best;
  logic ext_edge;
  logic data_pad;
  logic [2:0] mux_o;
  logic [2:0] mux_oe;

  // Pin function table, returns {oe, level}
  function automatic logic [1:0] pin_mux(input logic [4:0] fn, input int pin,
                                         input logic [6:0] src);
    logic [1:0] r;
    r = 2'b00;
    unique case (fn)
      FN_DEFAULT: r = {1'b1, (pin == 0) ? src[0] : (pin == 1) ? ~src[0] : src[1]};
      FN_TX_CLK: r = {1'b1, src[2]};
      FN_ANT1: r = {1'b1, src[3]};
      FN_ANT2: r = {1'b1, src[4]};
      FN_TX_RX_SWITCH: r = {1'b1, src[5]};
      FN_CLEAR_CH: r = {1'b1, src[6]};
      default: r = 2'b00;
    endcase
    return r;
  endfunction
  function automatic logic pin_is(input logic [7:0] cfg, input logic [4:0] fn);
    return cfg[PIN_FUNC_LSB +: 5] == fn;
  endfunction
  assign rx_entry = i_rx_state && !rx_q;
  // Register writes
  always_ff @(posedge i_core_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      ctrl2_q <= CTRL2_RST;
      for (int i = 0; i < NUM_PINS; i++) cfg_q[i] <= PIN_CFG_RST;
      io_port_q <= IO_PORT_RST;
      thr_q <= THRESHOLD_RST;
    end else if (i_reg_we) begin
      unique case (i_reg_addr)
        REG_CTRL2: ctrl2_q <= i_reg_wdata;
        REG_PIN0_CFG: cfg_q[0] <= i_reg_wdata;
        REG_PIN1_CFG: cfg_q[1] <= i_reg_wdata;
        REG_PIN2_CFG: cfg_q[2] <= i_reg_wdata;
        REG_IO_PORT: io_port_q <= i_reg_wdata;
        REG_THRESHOLD: thr_q <= i_reg_wdata;
        default: ;
      endcase
    end
  end

  // Strength sample taken once per four bit periods, in one cycle
  always_ff @(posedge i_core_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      bit_cnt_q <= 2'h0;
      strength_q <= STRENGTH_RST;
    end else if (i_bit_tick) begin
      bit_cnt_q <= bit_cnt_q + 2'h1;
      if (bit_cnt_q == REFRESH_LAST_BIT) strength_q <= i_strength_raw;
    end
  end

  // Read data; reading interrupt status clears the external flag
  always_ff @(posedge i_core_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      rdata_q <= 8'h00;
    end else if (i_reg_re) begin
      unique case (i_reg_addr)
        REG_CTRL2: rdata_q <= ctrl2_q;
        REG_PIN0_CFG: rdata_q <= cfg_q[0];
        REG_PIN1_CFG: rdata_q <= cfg_q[1];
        REG_PIN2_CFG: rdata_q <= cfg_q[2];
        REG_IO_PORT: rdata_q <= io_port_q;
        REG_STRENGTH: rdata_q <= strength_q;
        REG_THRESHOLD: rdata_q <= thr_q;
        REG_DEV_STATUS: rdata_q <= 8'(cc_q) << STAT_CLEAR_CH_BIT;
        REG_IRQ_STATUS: begin
          rdata_q <= (8'(ext_q) << STAT_EXT_IRQ_BIT) | (8'(cc_q) << STAT_CLEAR_CH_BIT);
        end
        default: rdata_q <= 8'h00;
      endcase
    end
  end

  // External interrupt edge; a new edge beats the read clear
  always_comb begin
    ext_edge = 1'b0;
    for (int i = 0; i < NUM_PINS; i++) begin
      if (pin_is(cfg_q[i], FN_EXT_IRQ_RISE) && link.pad[i] && !pad_in_q[i]) ext_edge = 1'b1;
    end
  end

  always_ff @(posedge i_core_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      pad_in_q <= 3'h0;
      ext_q <= 1'b0;
    end else begin
      pad_in_q <= link.pad;
      if (ext_edge && !i_shutdown) ext_q <= 1'b1;
      else if (i_reg_re && i_reg_addr == REG_IRQ_STATUS) ext_q <= 1'b0;
    end
  end

  // Radio state tracking and switch drive
  always_ff @(posedge i_core_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      rx_q <= 1'b0;
      active_q <= 1'b0;
      tx_rx_switch_q <= 1'b0;
    end else begin
      rx_q <= i_rx_state;
      active_q <= i_rx_state || i_tx_state;
      tx_rx_switch_q <= i_tx_state && !i_rx_state;
    end
  end

  gar_ant_div u_ant (
    .i_core_clk(i_core_clk),
    .i_rst_n(i_rst_n),
    .i_mode(ctrl2_q[ANT_MODE_LSB +: 3]),
    .i_active(active_q),
    .i_rx_entry(rx_entry),
    .i_preamble(i_preamble && i_rx_state),
    .i_sample(i_bit_tick),
    .i_strength(i_strength_raw),
    .o_ant1(ant1),
    .o_ant2(ant2),
    .o_best(best),
    .o_eval_done(eval_done)
  );

  // Clear channel decided after preamble; a decision beats the entry clear
  always_ff @(posedge i_core_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      cc_q <= 1'b0;
    end else if (eval_done) begin
      cc_q <= best > thr_q;
    end else if (rx_entry) begin
      cc_q <= 1'b0;
    end
  end

  // Direct mode: clock toggles per bit tick, data caught at its rise
  always_comb begin
    data_pad = 1'b0;
    for (int i = 0; i < NUM_PINS; i++) begin
      if (pin_is(cfg_q[i], FN_TX_DATA)) data_pad = link.pad[i];
    end
  end

  always_ff @(posedge i_core_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      tx_clk_q <= 1'b0;
      tx_data_q <= 1'b0;
      tx_valid_q <= 1'b0;
    end else begin
      tx_valid_q <= 1'b0;
      if (!i_direct_tx) begin
        tx_clk_q <= 1'b0;
      end else if (i_bit_tick) begin
        tx_clk_q <= ~tx_clk_q;
        if (!tx_clk_q) begin
          tx_data_q <= data_pad;
          tx_valid_q <= 1'b1;
        end
      end
    end
  end

  always_comb begin
    for (int i = 0; i < NUM_PINS; i++) begin
      {mux_oe[i], mux_o[i]} = pin_mux(cfg_q[i][PIN_FUNC_LSB +: 5], i,
                                      {cc_q, tx_rx_switch_q, ant2, ant1, tx_clk_q, i_mcu_clk, i_por});
    end
  end

  // Pads registered so they never glitch on a config write
  always_ff @(posedge i_core_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      pad_o_q <= 3'h0;
      pad_oe_q <= 3'h7;
      pad_pu_q <= 3'h0;
    end else if (i_shutdown) begin
      pad_o_q <= 3'h0;
      pad_oe_q <= 3'h7;
      pad_pu_q <= 3'h0;
    end else begin
      pad_o_q <= mux_o;
      pad_oe_q <= mux_oe;
      for (int i = 0; i < NUM_PINS; i++) pad_pu_q[i] <= cfg_q[i][PIN_PULLUP_BIT];
    end
  end

  assign link.dev_o = pad_o_q;
  assign link.dev_oe = pad_oe_q;
  assign link.dev_pu = pad_pu_q;
  assign o_reg_rdata = rdata_q;
  assign o_ext_irq = ext_q;
  assign o_clear_channel = cc_q;
  assign o_tx_data = tx_data_q;
  assign o_tx_data_valid = tx_valid_q;
  assign o_pin_drive_strength = {cfg_q[2][PIN_DRIVE_LSB +: 2], cfg_q[1][PIN_DRIVE_LSB +: 2],
                                 cfg_q[0][PIN_DRIVE_LSB +: 2]};
endmodule
`default_nettype wire

/* gar_host.sv */
// Host board end: direct-mode data source, sensor, switch readers
`timescale 1ns/100ps
`default_nettype none
module gar_host (
  // Clock and reset
  input wire logic i_core_clk,
  input wire logic i_rst_n,
  // Pads
  gar_link_if.host link,
  // Pin roles
  input wire gar_pkg::gar_pin_idx_t i_clk_pin,
  input wire gar_pkg::gar_pin_idx_t i_data_pin,
  input wire gar_pkg::gar_pin_idx_t i_sensor_pin,
  input wire gar_pkg::gar_pin_idx_t i_ant1_pin,
  input wire gar_pkg::gar_pin_idx_t i_ant2_pin,
  // Byte to send and sensor
  input wire logic i_load,
  input wire logic [7:0] i_byte,
  output logic o_busy,
  input wire logic i_sensor_en,
  input wire logic i_sensor,
  // Switch levels seen
  output logic o_ant1,
  output logic o_ant2
);
  import gar_pkg::*;
  logic [7:0] sh_q;
  logic [3:0] cnt_q;
  logic clk_prev_q;
  logic ant1_q;
  logic ant2_q;
  logic clk_fall;
  assign clk_fall = clk_prev_q && !link.pad[i_clk_pin];

  // Next bit presented after each falling clock, held through the rise
  always_ff @(posedge i_core_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      sh_q <= 8'h00;
      cnt_q <= 4'h0;
      clk_prev_q <= 1'b0;
    end else begin
      clk_prev_q <= link.pad[i_clk_pin];
      if (i_load && cnt_q == 4'h0) begin
        sh_q <= i_byte;
        cnt_q <= 4'h8;
      end else if (clk_fall && cnt_q != 4'h0) begin
        sh_q <= {sh_q[6:0], 1'b0};
        cnt_q <= cnt_q - 4'h1;
      end
    end
  end

  always_ff @(posedge i_core_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      ant1_q <= 1'b0;
      ant2_q <= 1'b0;
    end else begin
      ant1_q <= link.pad[i_ant1_pin];
      ant2_q <= link.pad[i_ant2_pin];
    end
  end

  always_comb begin
    link.host_o = 3'h0;
    link.host_oe = 3'h0;
    if (cnt_q != 4'h0) begin
      link.host_o[i_data_pin] = sh_q[7];
      link.host_oe[i_data_pin] = 1'b1;
    end
    if (i_sensor_en) begin
      link.host_o[i_sensor_pin] = i_sensor;
      link.host_oe[i_sensor_pin] = 1'b1;
    end
  end
  assign o_busy = cnt_q != 4'h0;
  assign o_ant1 = ant1_q;
  assign o_ant2 = ant2_q;
endmodule
`default_nettype wire

/* gar_link_checker.sv */
// Concurrent checks on the pad link and device status ports
`timescale 1ns/100ps
`default_nettype none
module gar_link_checker (
  // Clock and reset
  input wire logic i_core_clk,
  input wire logic i_rst_n,
  // Link signals
  input wire logic [2:0] dev_o,
  input wire logic [2:0] dev_oe,
  input wire logic [2:0] dev_pu,
  input wire logic [2:0] pad,
  // Device side
  input wire logic i_shutdown,
  input wire logic i_rx_state,
  input wire logic i_bit_tick,
  input wire logic [6:0] i_reg_addr,
  input wire logic i_reg_re,
  input wire logic [7:0] o_reg_rdata,
  input wire logic o_ext_irq,
  input wire logic o_clear_channel,
  input wire logic o_tx_data_valid
);
  import gar_pkg::*;
  default clocking cb @(posedge i_core_clk);
  endclocking
  default disable iff (!i_rst_n);

  shutdown_pads_a: assert property ($past(i_shutdown) |->
    dev_oe == 3'b111 && dev_o == 3'b000 && dev_pu == 3'b000 && pad == 3'b000)
    else $error("pads not held low in shutdown");
  irq_sticky_a: assert property ($fell(o_ext_irq) |->
    $past(i_reg_re) && $past(i_reg_addr) == REG_IRQ_STATUS)
    else $error("interrupt flag dropped without status read");
  irq_cause_a: assert property ($rose(o_ext_irq) |->
    ($past(pad) & ~$past(pad, 2)) != 3'b000)
    else $error("interrupt flag set without a pad rising edge");
  tx_pulse_a: assert property (o_tx_data_valid |=> !o_tx_data_valid)
    else $error("transmit data valid longer than one cycle");
  tx_cause_a: assert property (o_tx_data_valid |->
    $past(i_bit_tick) || $past(i_bit_tick, 2))
    else $error("transmit data captured without a bit tick");
  cc_rx_clear_a: assert property ($rose(i_rx_state) |-> ##[1:2] !o_clear_channel)
    else $error("clear channel not cleared on receive entry");
  rdata_hold_a: assert property (!$past(i_reg_re) |-> $stable(o_reg_rdata))
    else $error("read data changed without a read");
  unmapped_read_a: assert property ($past(i_reg_re) && $past(i_reg_addr) == 7'h7F |->
    o_reg_rdata == 8'h00)
    else $error("unmapped read returned nonzero");
endmodule
`default_nettype wire

/* gpio_antenna_rssi_control_bench.sv */
// Testbench joining device and host ends across the pad link
`timescale 1ns/100ps
`default_nettype none
module gpio_antenna_rssi_control_bench;
  import gar_pkg::*;
  logic i_core_clk = 1'b0;
  logic i_rst_n = 1'b0;
  logic shutdown = 1'b0, rx_state = 1'b0, tx_state = 1'b0, por = 1'b0, mcu_clk = 1'b0;
  logic direct_tx = 1'b0, bit_tick = 1'b0, preamble = 1'b0;
  logic [7:0] strength_raw = 8'h00, reg_wdata = 8'h00, byte_in = 8'h00;
  logic [6:0] reg_addr = 7'h00;
  logic reg_we = 1'b0, reg_re = 1'b0, load = 1'b0, sensor_en = 1'b0, sensor = 1'b0;
  gar_pin_idx_t clk_pin = 2'h0, data_pin = 2'h1, sensor_pin = 2'h2;
  gar_pin_idx_t ant1_pin = 2'h0, ant2_pin = 2'h1;
  wire logic [7:0] reg_rdata;
  wire logic [5:0] drive_strength;
  wire logic ext_irq, clear_channel, tx_data, tx_data_valid, busy, h_ant1, h_ant2;
  int miscompares = 0;
  int total_checks = 0;

  always #5 i_core_clk = ~i_core_clk;

  gar_link_if link ();
  gar_dev u_gar_dev (.i_core_clk(i_core_clk), .i_rst_n(i_rst_n), .link(link.dev),
    .i_shutdown(shutdown), .i_rx_state(rx_state), .i_tx_state(tx_state), .i_por(por),
    .i_mcu_clk(mcu_clk), .i_direct_tx(direct_tx), .i_bit_tick(bit_tick),
    .i_preamble(preamble), .i_strength_raw(strength_raw), .i_reg_addr(reg_addr),
    .i_reg_wdata(reg_wdata), .i_reg_we(reg_we), .i_reg_re(reg_re), .o_reg_rdata(reg_rdata),
    .o_ext_irq(ext_irq), .o_clear_channel(clear_channel), .o_tx_data(tx_data),
    .o_tx_data_valid(tx_data_valid), .o_pin_drive_strength(drive_strength));
  gar_host u_gar_host (.i_core_clk(i_core_clk), .i_rst_n(i_rst_n), .link(link.host),
    .i_clk_pin(clk_pin), .i_data_pin(data_pin), .i_sensor_pin(sensor_pin),
    .i_ant1_pin(ant1_pin), .i_ant2_pin(ant2_pin), .i_load(load), .i_byte(byte_in),
    .o_busy(busy), .i_sensor_en(sensor_en), .i_sensor(sensor), .o_ant1(h_ant1),
    .o_ant2(h_ant2));
  gar_link_checker u_chk (.i_core_clk(i_core_clk), .i_rst_n(i_rst_n), .dev_o(link.dev_o),
    .dev_oe(link.dev_oe), .dev_pu(link.dev_pu), .pad(link.pad), .i_shutdown(shutdown),
    .i_rx_state(rx_state), .i_bit_tick(bit_tick), .i_reg_addr(reg_addr), .i_reg_re(reg_re),
    .o_reg_rdata(reg_rdata), .o_ext_irq(ext_irq), .o_clear_channel(clear_channel),
    .o_tx_data_valid(tx_data_valid));

  task automatic cyc(input int n);
    repeat (n) @(posedge i_core_clk);
    #1;
  endtask
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    total_checks++;
    if (got !== exp) begin
      miscompares++;
      $display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [6:0] a, input logic [7:0] d);
    reg_addr = a;
    reg_wdata = d;
    reg_we = 1'b1;
    cyc(1);
    reg_we = 1'b0;
    cyc(1);
  endtask
  task automatic rd(input logic [6:0] a, output logic [7:0] d);
    reg_addr = a;
    reg_re = 1'b1;
    cyc(1);
    reg_re = 1'b0;
    cyc(1);
    d = reg_rdata;
  endtask
  task automatic tick;
    bit_tick = 1'b1;
    cyc(1);
    bit_tick = 1'b0;
    cyc(1);
  endtask
  task automatic test_done;
    $display("checks=%0d miscompares=%0d", total_checks, miscompares);
    if (miscompares == 0 && total_checks > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  // Must run before any other tick so the refresh phase is known
  task automatic t_strength;
    logic [7:0] d;
    strength_raw = 8'h5A;
    repeat (3) tick();
    rd(REG_STRENGTH, d);
    chk(d, STRENGTH_RST);
    tick();
    rd(REG_STRENGTH, d);
    chk(d, 8'h5A);
    strength_raw = 8'h33;
    wr(REG_STRENGTH, 8'hFF);
    rd(REG_STRENGTH, d);
    chk(d, 8'h5A);
  endtask
  task automatic t_regs;
    logic [7:0] d;
    logic [6:0] addrs [6];
    addrs = '{REG_CTRL2, REG_PIN0_CFG, REG_PIN1_CFG, REG_PIN2_CFG, REG_IO_PORT, REG_THRESHOLD};
    foreach (addrs[k]) begin
      rd(addrs[k], d);
      chk(d, 8'h00);
    end
    wr(REG_THRESHOLD, 8'hA5);
    rd(REG_THRESHOLD, d);
    chk(d, 8'hA5);
    // Unlisted code releases the pin onto its pull-up
    wr(REG_PIN0_CFG, 8'hFF);
    rd(REG_PIN0_CFG, d);
    chk(d, 8'hFF);
    chk({2'h0, drive_strength}, 8'h03);
    chk({7'h00, link.pad[0]}, 8'h01);
    wr(REG_PIN0_CFG, 8'h00);
    wr(7'h7F, 8'hFF);
    rd(7'h7F, d);
    chk(d, 8'h00);
  endtask
  task automatic t_default;
    por = 1'b1;
    cyc(3);
    chk({5'h00, link.pad}, 8'h01);
    por = 1'b0;
    mcu_clk = 1'b1;
    cyc(3);
    chk({5'h00, link.pad}, 8'h06);
  endtask
  task automatic t_irq_shutdown;
    logic [7:0] d;
    wr(REG_PIN2_CFG, {3'b000, FN_EXT_IRQ_RISE});
    sensor_en = 1'b1;
    cyc(3);
    sensor = 1'b1;
    cyc(3);
    chk(ext_irq, 1'b1);
    rd(REG_IRQ_STATUS, d);
    chk(d, 8'h01);
    rd(REG_IRQ_STATUS, d);
    chk(d, 8'h00);
    shutdown = 1'b1;
    cyc(2);
    chk({5'h00, link.pad}, 8'h00);
    shutdown = 1'b0;
    cyc(3);
    chk({5'h00, link.pad}, 8'h06);
    sensor_en = 1'b0;
  endtask
  task automatic t_ant;
    logic [2:0] m;
    wr(REG_PIN0_CFG, {3'b000, FN_ANT1});
    wr(REG_PIN1_CFG, {3'b000, FN_ANT2});
    for (int k = 0; k < 8; k++) begin
      m = k[2:0];
      wr(REG_CTRL2, {m, 5'h00});
      cyc(3);
      chk({6'h00, link.pad[1:0]}, m[2] ? {6'h00, m[0], m[0]} : {6'h00, m[1], m[1]});
      if (!m[2]) begin
        rx_state = 1'b1;
        cyc(3);
        chk({6'h00, link.pad[1:0]}, {6'h00, ~m[0], m[0]});
        chk(h_ant1, m[0]);
        chk(h_ant2, !m[0]);
        rx_state = 1'b0;
        cyc(2);
      end
    end
  endtask
  task automatic t_div;
    logic [7:0] d;
    wr(REG_THRESHOLD, 8'h40);
    wr(REG_CTRL2, 8'h80);
    rx_state = 1'b1;
    preamble = 1'b1;
    for (int k = 0; k < 64; k++) begin
      // Antenna 2 is the stronger path
      strength_raw = link.pad[0] ? 8'h30 : 8'h70;
      bit_tick = (k % 2 == 0);
      cyc(1);
      if (k > 2) chk(link.pad[0] ^ link.pad[1], 1'b1);
    end
    bit_tick = 1'b0;
    preamble = 1'b0;
    cyc(4);
    chk({6'h00, link.pad[1:0]}, 8'h02);
    chk(clear_channel, 1'b1);
    rd(REG_DEV_STATUS, d);
    chk(d[STAT_CLEAR_CH_BIT], 1'b1);
    rx_state = 1'b0;
    tx_state = 1'b1;
    cyc(3);
    chk({6'h00, link.pad[1:0]}, 8'h02);
    tx_state = 1'b0;
    cyc(3);
    chk({6'h00, link.pad[1:0]}, 8'h00);
  endtask
  task automatic t_txrx;
    wr(REG_PIN2_CFG, {3'b000, FN_TX_RX_SWITCH});
    tx_state = 1'b1;
    cyc(3);
    chk(link.pad[2], 1'b1);
    tx_state = 1'b0;
    rx_state = 1'b1;
    cyc(3);
    chk(link.pad[2], 1'b0);
    chk(clear_channel, 1'b0);
    rx_state = 1'b0;
    cyc(2);
  endtask
  task automatic t_beacon;
    wr(REG_CTRL2, 8'hC0);
    rx_state = 1'b1;
    preamble = 1'b1;
    for (int k = 0; k < 16; k++) begin
      // Later antenna 1 samples are stronger, but beacon keeps the first
      strength_raw = link.pad[0] ? ((k < 4) ? 8'h30 : 8'h90) : 8'h70;
      bit_tick = (k % 2 == 0);
      cyc(1);
    end
    bit_tick = 1'b0;
    preamble = 1'b0;
    cyc(4);
    chk({6'h00, link.pad[1:0]}, 8'h02);
    chk(clear_channel, 1'b1);
    rx_state = 1'b0;
    cyc(3);
    chk({6'h00, link.pad[1:0]}, 8'h00);
  endtask
  task automatic t_direct;
    logic [7:0] got;
    int n;
    n = 0;
    got = 8'h00;
    wr(REG_CTRL2, 8'h00);
    wr(REG_PIN0_CFG, {3'b000, FN_TX_CLK});
    wr(REG_PIN1_CFG, {3'b000, FN_TX_DATA});
    cyc(2);
    byte_in = 8'hC5;
    load = 1'b1;
    cyc(1);
    load = 1'b0;
    chk(busy, 1'b1);
    direct_tx = 1'b1;
    for (int k = 0; k < 400 && n < 8; k++) begin
      bit_tick = (k % 4 == 0);
      cyc(1);
      if (tx_data_valid === 1'b1) begin
        got = {got[6:0], tx_data};
        n++;
      end
    end
    bit_tick = 1'b0;
    direct_tx = 1'b0;
    chk(got, 8'hC5);
    cyc(4);
    chk(busy, 1'b0);
  endtask

  initial begin
    repeat (12) @(posedge i_core_clk);
    #1;
    i_rst_n = 1'b1;
    t_strength();
    t_regs();
    t_default();
    t_irq_shutdown();
    t_ant();
    t_div();
    t_txrx();
    t_beacon();
    t_direct();
    test_done();
  end
  // Whole run needs a few hundred cycles
  initial begin
    #100000;
    miscompares++;
    test_done();
  end
endmodule
`default_nettype wire
